// *** asid_pkg.sv ***
// Overview of operation
// - one limit function drives the alert, conversion-done may drive it too
// - alert function flag at bit 4 shows a limit event caused the alert
// - latched mode: alert function flag clears only by reading mask register
// - transparent mode: flag clears after next conversion without alert condition
// - conversion done flag at bit 3 sets when the whole cycle finishes
// - configuration write clears conversion done flag unless power-down selected
// - a read of the mask register clears the conversion done flag unless a conversion completes in the same cycle
// - results of the last completed conversion are held, but no register address reads them
// - math overflow flag at bit 2 sets when arithmetic overflows
// - bit 1 selects alert sense: one active-high, zero active-low default
// - latch select bit sets latching of the alert function flag and so of the alert output
// - 16-bit threshold at 07h, reset zero, compared with selected register
// - read-only 16-bit maker code register at FEh
// - read-only die register at FFh: 12-bit code high, 4-bit revision low
// - mask bits 15 to 10 choose the event that drives the alert
// - several limit enables: highest bit among 15 to 11 wins
package asid_pkg;
	localparam int unsigned ASID_ADDR_W = 8;
	localparam int unsigned ASID_DATA_W = 16;
	localparam logic [7:0] ASID_OFS_CONFIG    = 8'h00;
	localparam logic [7:0] ASID_OFS_MASK      = 8'h06;
	localparam logic [7:0] ASID_OFS_THRESHOLD = 8'h07;
	localparam logic [7:0] ASID_OFS_MAKER     = 8'hFE;
	localparam logic [7:0] ASID_OFS_DIE       = 8'hFF;
	// mask/enable bit positions
	localparam int unsigned ASID_BIT_SHUNT_OVER  = 15;
	localparam int unsigned ASID_BIT_SHUNT_UNDER = 14;
	localparam int unsigned ASID_BIT_BUS_OVER    = 13;
	localparam int unsigned ASID_BIT_BUS_UNDER   = 12;
	localparam int unsigned ASID_BIT_POWER_OVER  = 11;
	localparam int unsigned ASID_BIT_CONV_ALERT  = 10;
	localparam int unsigned ASID_BIT_ALERT_FLAG  = 4;
	localparam int unsigned ASID_BIT_DONE_FLAG   = 3;
	localparam int unsigned ASID_BIT_OVERFLOW    = 2;
	localparam int unsigned ASID_BIT_SENSE       = 1;
	localparam int unsigned ASID_BIT_LATCH       = 0;
	localparam logic [15:0] ASID_MASK_RW_BITS    = 16'hFC03;
	localparam logic [15:0] ASID_MASK_RESET      = 16'h0000;
	localparam logic [15:0] ASID_THRESHOLD_RESET = 16'h0000;
	localparam logic [15:0] ASID_READ_ZERO       = 16'h0000;
	// operating mode field of the configuration register
	localparam logic [1:0] ASID_MODE_RUN_MASK = 2'h3;
	localparam logic [1:0] ASID_MODE_PWRDOWN  = 2'h0;
	// identification defaults, values are arbitrary
	localparam logic [15:0] ASID_MAKER_DEFAULT = 16'h5A3C;
	localparam logic [11:0] ASID_DIE_DEFAULT   = 12'h0B7;
	localparam logic [3:0]  ASID_REV_DEFAULT   = 4'h1;
endpackage

// *** asid_evt_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// carries limit selection and alert state between the register bank and its helpers
interface asid_evt_if;
	logic [5:0]  alert_enable;
	logic [15:0] threshold;
	logic [15:0] shunt_value;
	logic [15:0] bus_value;
	logic [15:0] power_value;
	logic        limit_hit;
	logic        alert_active;
	logic        alert_sense_select;

	modport cmp
	(
		input  alert_enable,
		input  threshold,
		input  shunt_value,
		input  bus_value,
		input  power_value,
		output limit_hit
	);

	modport pin
	(
		input  alert_active,
		input  alert_sense_select
	);

	modport bank
	(
		output alert_enable,
		output threshold,
		output shunt_value,
		output bus_value,
		output power_value,
		input  limit_hit,
		output alert_active,
		output alert_sense_select
	);
endinterface
`default_nettype wire

// *** asid_limit_cmp.sv ***
`timescale 1ns/1ps
`default_nettype none
module asid_limit_cmp
	import asid_pkg::*;
(
	asid_evt_if.cmp evt
);
	// ------------------------------------------------------------
	// limit comparison
	// ------------------------------------------------------------
	// highest enable wins
	always_comb
	begin
		if (evt.alert_enable[ASID_BIT_SHUNT_OVER - ASID_BIT_CONV_ALERT])
		begin
			evt.limit_hit = $signed(evt.shunt_value) > $signed(evt.threshold);
		end
		else if (evt.alert_enable[ASID_BIT_SHUNT_UNDER - ASID_BIT_CONV_ALERT])
		begin
			evt.limit_hit = $signed(evt.shunt_value) < $signed(evt.threshold);
		end
		else if (evt.alert_enable[ASID_BIT_BUS_OVER - ASID_BIT_CONV_ALERT])
		begin
			evt.limit_hit = evt.bus_value > evt.threshold;
		end
		else if (evt.alert_enable[ASID_BIT_BUS_UNDER - ASID_BIT_CONV_ALERT])
		begin
			evt.limit_hit = evt.bus_value < evt.threshold;
		end
		else if (evt.alert_enable[ASID_BIT_POWER_OVER - ASID_BIT_CONV_ALERT])
		begin
			evt.limit_hit = evt.power_value > evt.threshold;
		end
		else
		begin
			evt.limit_hit = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** asid_pin_drv.sv ***
`timescale 1ns/1ps
`default_nettype none
module asid_pin_drv
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	asid_evt_if.pin   evt,
	output var  logic pin_oe_n_o
);
	// ------------------------------------------------------------
	// open-collector drive
	// ------------------------------------------------------------
	// sense select
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			pin_oe_n_o <= 1'b1;
		end
		else
		begin
			pin_oe_n_o <= ~(evt.alert_active ^ evt.alert_sense_select);
		end
	end

	a_pin_sense_drive: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(evt.alert_active ^ evt.alert_sense_select) |=> !pin_oe_n_o)
		else $error("alert pin not pulled low when required");
endmodule
`default_nettype wire

// *** asid_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module asid_top
	import asid_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE = ASID_MAKER_DEFAULT,
	parameter logic [11:0] DIE_CODE   = ASID_DIE_DEFAULT,
	parameter logic [3:0]  DIE_REV    = ASID_REV_DEFAULT
)
(
	input  wire logic                   clk_i,
	input  wire logic                   rstn_i,
	input  wire logic [ASID_ADDR_W-1:0] reg_addr_i,
	input  wire logic [ASID_DATA_W-1:0] reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output var  logic [ASID_DATA_W-1:0] reg_rdata_o,
	input  wire logic                   conv_done_i,
	input  wire logic                   overflow_i,
	input  wire logic [15:0]            shunt_value_i,
	input  wire logic [15:0]            bus_value_i,
	input  wire logic [15:0]            power_value_i,
	input  wire logic                   alert_pin_i,
	output var  logic                   alert_pin_o,
	output var  logic                   alert_pin_oe_n_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [5:0]  alert_enable;
	logic        alert_sense_select;
	logic        alert_latch_select;
	logic [15:0] alert_threshold_bits;
	logic        alert_function_flag;
	logic        conversion_done_flag;
	logic        math_overflow_flag;
	logic [15:0] last_shunt;
	logic [15:0] last_bus;
	logic [15:0] last_power;
	logic        mask_rd;
	logic        mask_wr;
	logic        thr_wr;
	logic        cfg_clear;
	logic        conv_hit;
	logic [15:0] mask_view;
	logic [15:0] next_rdata;

	asid_evt_if evt ();

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	assign mask_rd  = reg_rd_i && (reg_addr_i == ASID_OFS_MASK);
	assign mask_wr  = reg_wr_i && (reg_addr_i == ASID_OFS_MASK);
	assign thr_wr   = reg_wr_i && (reg_addr_i == ASID_OFS_THRESHOLD);
	assign cfg_clear = reg_wr_i && (reg_addr_i == ASID_OFS_CONFIG)
		&& ((reg_wdata_i[1:0] & ASID_MODE_RUN_MASK) != ASID_MODE_PWRDOWN);
	assign conv_hit = conv_done_i && evt.limit_hit;

	// ------------------------------------------------------------
	// helper connections
	// ------------------------------------------------------------
	assign evt.alert_enable       = alert_enable;
	assign evt.threshold          = alert_threshold_bits;
	assign evt.shunt_value        = shunt_value_i;
	assign evt.bus_value          = bus_value_i;
	assign evt.power_value        = power_value_i;
	assign evt.alert_sense_select = alert_sense_select;
	assign evt.alert_active = alert_function_flag
		|| (alert_enable[0] && conversion_done_flag);

	asid_limit_cmp u_cmp
	(
		.evt (evt.cmp)
	);

	asid_pin_drv u_pin
	(
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.evt        (evt.pin),
		.pin_oe_n_o (alert_pin_oe_n_o)
	);

	// ------------------------------------------------------------
	// writable control
	// ------------------------------------------------------------
	// event selection bits
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			alert_enable       <= ASID_MASK_RESET[ASID_BIT_SHUNT_OVER:ASID_BIT_CONV_ALERT];
			alert_sense_select <= ASID_MASK_RESET[ASID_BIT_SENSE];
			alert_latch_select <= ASID_MASK_RESET[ASID_BIT_LATCH];
		end
		else if (mask_wr)
		begin
			alert_enable       <= reg_wdata_i[ASID_BIT_SHUNT_OVER:ASID_BIT_CONV_ALERT];
			alert_sense_select <= reg_wdata_i[ASID_BIT_SENSE];
			alert_latch_select <= reg_wdata_i[ASID_BIT_LATCH];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			alert_threshold_bits <= ASID_THRESHOLD_RESET;
		end
		else if (thr_wr)
		begin
			alert_threshold_bits <= reg_wdata_i;
		end
	end

	// ------------------------------------------------------------
	// status flags
	// ------------------------------------------------------------
	// set on a limit hit, wins over clears
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			alert_function_flag <= 1'b0;
		end
		else if (conv_hit)
		begin
			alert_function_flag <= 1'b1;
		end
		// latched: only a mask read clears
		else if (alert_latch_select)
		begin
			if (mask_rd)
			begin
				alert_function_flag <= 1'b0;
			end
		end
		else if (conv_done_i)
		begin
			alert_function_flag <= 1'b0;
		end
	end

	// set at end of cycle, wins over clears
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			conversion_done_flag <= 1'b0;
		end
		else if (conv_done_i)
		begin
			conversion_done_flag <= 1'b1;
		end
		else if (mask_rd || cfg_clear)
		begin
			conversion_done_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			math_overflow_flag <= 1'b0;
		end
		else if (conv_done_i)
		begin
			math_overflow_flag <= overflow_i;
		end
		else if (overflow_i)
		begin
			math_overflow_flag <= 1'b1;
		end
	end

	// results of the last completed conversion
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			last_shunt <= ASID_READ_ZERO;
			last_bus   <= ASID_READ_ZERO;
			last_power <= ASID_READ_ZERO;
		end
		else if (conv_done_i)
		begin
			last_shunt <= shunt_value_i;
			last_bus   <= bus_value_i;
			last_power <= power_value_i;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb
	begin
		mask_view = ASID_READ_ZERO;
		mask_view[ASID_BIT_SHUNT_OVER:ASID_BIT_CONV_ALERT] = alert_enable;
		mask_view[ASID_BIT_ALERT_FLAG] = alert_function_flag;
		mask_view[ASID_BIT_DONE_FLAG]  = conversion_done_flag;
		mask_view[ASID_BIT_OVERFLOW]   = math_overflow_flag;
		mask_view[ASID_BIT_SENSE] = alert_sense_select;
		mask_view[ASID_BIT_LATCH] = alert_latch_select;
	end

	// maker code, die code, no write path to either
	always_comb
	begin
		if (reg_addr_i == ASID_OFS_MASK)
		begin
			next_rdata = mask_view;
		end
		else if (reg_addr_i == ASID_OFS_THRESHOLD)
		begin
			next_rdata = alert_threshold_bits;
		end
		else if (reg_addr_i == ASID_OFS_MAKER)
		begin
			next_rdata = MAKER_CODE;
		end
		else if (reg_addr_i == ASID_OFS_DIE)
		begin
			next_rdata = {DIE_CODE, DIE_REV};
		end
		else
		begin
			next_rdata = ASID_READ_ZERO;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			reg_rdata_o <= ASID_READ_ZERO;
		end
		else if (reg_rd_i)
		begin
			reg_rdata_o <= next_rdata;
		end
	end

	// open collector only ever pulls low
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			alert_pin_o <= 1'b0;
		end
		else
		begin
			alert_pin_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_flag_limit_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_hit |=> alert_function_flag)
		else $error("alert function flag missed a limit hit");

	a_flag_latch_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(alert_latch_select && alert_function_flag && !mask_rd && !mask_wr)
		|=> alert_function_flag)
		else $error("latched alert flag cleared without mask read");

	a_flag_latch_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(alert_latch_select && mask_rd && !conv_hit) |=> !alert_function_flag)
		else $error("latched alert flag survived mask read");

	a_flag_transp_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(!alert_latch_select && conv_done_i && !evt.limit_hit)
		|=> !alert_function_flag)
		else $error("transparent alert flag not cleared");

	a_done_flag_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_done_i |=> conversion_done_flag)
		else $error("conversion done flag not set");

	a_done_rise_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(conversion_done_flag) |-> $past(conv_done_i))
		else $error("conversion done flag set without conversion");

	a_done_cfg_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(cfg_clear && !conv_done_i) |=> !conversion_done_flag)
		else $error("config write did not clear conversion done flag");

	a_done_read_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(mask_rd && !conv_done_i) ##1 !conv_done_i |-> !conversion_done_flag)
		else $error("mask read did not clear conversion done flag");

	a_overflow_flag_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		overflow_i |=> math_overflow_flag)
		else $error("overflow flag not set");

	a_result_keep_last: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_done_i |=> {last_shunt, last_bus, last_power}
			== $past({shunt_value_i, bus_value_i, power_value_i}))
		else $error("last conversion results not captured");

	a_thr_write_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
		thr_wr ##1 !thr_wr ##1 (reg_rd_i && reg_addr_i == ASID_OFS_THRESHOLD && !thr_wr)
		|=> reg_rdata_o == $past(reg_wdata_i, 3))
		else $error("threshold readback mismatch");

	a_id_read_fixed: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(reg_rd_i && reg_addr_i == ASID_OFS_MAKER) |=> reg_rdata_o == MAKER_CODE)
		else $error("maker code readback wrong");

	a_die_read_fixed: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(reg_rd_i && reg_addr_i == ASID_OFS_DIE) |=> reg_rdata_o == {DIE_CODE, DIE_REV})
		else $error("die code readback wrong");
endmodule
`default_nettype wire

// *** asid_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module asid_host_model
	import asid_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   pin_oe_n_i,
	output var  logic                   pin_level_o,
	output var  logic [ASID_ADDR_W-1:0] addr_o,
	output var  logic [ASID_DATA_W-1:0] wdata_o,
	output var  logic                   wr_o,
	output var  logic                   rd_o
);
	// ---------------------------------------------------------------
	// open-drain alert wire, pulled up when released
	// ---------------------------------------------------------------
	assign pin_level_o = pin_oe_n_i ? 1'b1 : 1'b0;

	initial
	begin
		addr_o  = 8'h00;
		wdata_o = 16'h0000;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
	end

	// ---------------------------------------------------------------
	// one register access, entered just after a rising edge
	// ---------------------------------------------------------------
	task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
		addr_o  = a;
		wdata_o = d;
		wr_o    = w;
		rd_o    = ~w;
		@(posedge clk_i);
		#1;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
		// released bus shows the inverse of the last value
		addr_o  = ~a;
		wdata_o = ~d;
		@(posedge clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// *** test_alert_status_and_id_registers.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_alert_status_and_id_registers
	import asid_pkg::*;
;
	// identification values are arbitrary
	localparam logic [15:0] MAKER = 16'h3C5A;
	localparam logic [11:0] DIE   = 12'h4D2;
	localparam logic [3:0]  REV   = 4'h6;

	logic        clk_i;
	logic        rstn_i;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        conv_done;
	logic        overflow;
	logic [15:0] shunt;
	logic [15:0] bus;
	logic [15:0] power;
	logic        pin_level;
	logic        pin_o;
	logic        pin_oe_n;
	int          errors;
	int          comparisons;
	int          cycles;
	logic [15:0] exp_q[$];
	logic [15:0] t;
	logic [15:0] v;

	asid_top #(.MAKER_CODE(MAKER), .DIE_CODE(DIE), .DIE_REV(REV)) i_asid_top
	(
		.clk_i            (clk_i),
		.rstn_i           (rstn_i),
		.reg_addr_i       (reg_addr),
		.reg_wdata_i      (reg_wdata),
		.reg_wr_i         (reg_wr),
		.reg_rd_i         (reg_rd),
		.reg_rdata_o      (reg_rdata),
		.conv_done_i      (conv_done),
		.overflow_i       (overflow),
		.shunt_value_i    (shunt),
		.bus_value_i      (bus),
		.power_value_i    (power),
		.alert_pin_i      (pin_level),
		.alert_pin_o      (pin_o),
		.alert_pin_oe_n_o (pin_oe_n)
	);

	asid_host_model i_asid_host_model
	(
		.clk_i       (clk_i),
		.pin_oe_n_i  (pin_oe_n),
		.pin_level_o (pin_level),
		.addr_o      (reg_addr),
		.wdata_o     (reg_wdata),
		.wr_o        (reg_wr),
		.rd_o        (reg_rd)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// checking and closing
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// read data appears after the read edge; oldest note is compared
	always @(posedge clk_i)
	begin
		if (rstn_i === 1'b1 && reg_rd === 1'b1)
		begin
			#1;
			check(reg_rdata, exp_q.pop_front(), "read data");
		end
	end

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			errors++;
			results();
		end
	end

	// ---------------------------------------------------------------
	// stimulus tasks
	// ---------------------------------------------------------------
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		exp_q.push_back(exp);
		i_asid_host_model.access(1'b0, a, 16'h0000);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_asid_host_model.access(1'b1, a, d);
	endtask

	task automatic conv(input logic [15:0] s, input logic [15:0] b, input logic [15:0] p,
		input logic o);
		shunt     = s;
		bus       = b;
		power     = p;
		overflow  = o;
		conv_done = 1'b1;
		@(posedge clk_i);
		#1;
		conv_done = 1'b0;
		overflow  = 1'b0;
		shunt     = 16'($urandom);
		bus       = 16'($urandom);
		power     = 16'($urandom);
		@(posedge clk_i);
		#1;
	endtask

	task automatic pin(input logic exp);
		@(posedge clk_i);
		#1;
		check({15'h0000, pin_oe_n}, {15'h0000, exp}, "alert pin enable");
		check({15'h0000, pin_o}, 16'h0000, "alert pin data");
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		errors      = 0;
		comparisons = 0;
		cycles      = 0;
		rstn_i      = 1'b0;
		conv_done   = 1'b0;
		overflow    = 1'b0;
		shunt       = 16'h0000;
		bus         = 16'h0000;
		power       = 16'h0000;
		void'($urandom(26));
		t = 16'($urandom_range(16'h7000, 16'h0100));
		repeat (20) @(posedge clk_i);
		#1;
		rstn_i = 1'b1;
		rd(ASID_OFS_MASK, 16'h0000);
		rd(ASID_OFS_THRESHOLD, 16'h0000);
		rd(ASID_OFS_MAKER, MAKER);
		rd(ASID_OFS_DIE, {DIE, REV});
		wr(ASID_OFS_MAKER, ~MAKER);
		wr(ASID_OFS_DIE, 16'h0000);
		rd(ASID_OFS_MAKER, MAKER);
		rd(ASID_OFS_DIE, {DIE, REV});
		wr(ASID_OFS_THRESHOLD, t);
		rd(ASID_OFS_THRESHOLD, t);
		rd(8'h42, 16'h0000);
		wr(ASID_OFS_MASK, 16'hFFFF);
		rd(ASID_OFS_MASK, 16'hFC03);
		pin(1'b0);
		wr(ASID_OFS_MASK, 16'h8001);
		pin(1'b1);
		conv(t + 16'h0001, t, t, 1'b0);
		pin(1'b0);
		conv(t - 16'h0001, t, t, 1'b0);
		rd(ASID_OFS_MASK, 16'h8019);
		rd(ASID_OFS_MASK, 16'h8001);
		pin(1'b1);
		wr(ASID_OFS_MASK, 16'h8000);
		conv(t + 16'h0001, t, t, 1'b1);
		rd(ASID_OFS_MASK, 16'h801C);
		conv(t, t, t, 1'b0);
		rd(ASID_OFS_MASK, 16'h8008);
		conv(t, t, t, 1'b0);
		wr(ASID_OFS_CONFIG, 16'h0000);
		rd(ASID_OFS_MASK, 16'h8008);
		conv(t, t, t, 1'b0);
		wr(ASID_OFS_CONFIG, 16'h4127);
		rd(ASID_OFS_MASK, 16'h8000);
		for (int i = 0; i < 5; i++)
		begin
			v = (i % 2 == 0) ? t + 16'h0001 : t - 16'h0001;
			wr(ASID_OFS_MASK, 16'h8000 >> i);
			conv(i < 2 ? v : t, (i == 2 || i == 3) ? v : t, i == 4 ? v : t, 1'b0);
			rd(ASID_OFS_MASK, (16'h8000 >> i) | 16'h0018);
		end
		wr(ASID_OFS_MASK, 16'h2800);
		conv(t, t, 16'hFFFF, 1'b0);
		rd(ASID_OFS_MASK, 16'h2808);
		wr(ASID_OFS_MASK, 16'h0400);
		conv(t, t, t, 1'b0);
		pin(1'b0);
		rd(ASID_OFS_MASK, 16'h0408);
		pin(1'b1);
		wr(ASID_OFS_MASK, 16'h0402);
		conv(t, t, t, 1'b0);
		pin(1'b1);
		// reset in mid-run must bring the mask and threshold back
		rstn_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		rstn_i = 1'b1;
		rd(ASID_OFS_MASK, ASID_MASK_RESET);
		rd(ASID_OFS_THRESHOLD, ASID_THRESHOLD_RESET);
		pin(1'b1);
		results();
	end
endmodule
`default_nettype wire
